// ==== hdl/meter_pkg.sv ====
// Purpose: shared constants for the metering engine and its processor port
// Assumes: 40 MHz system clock, engine memory of 256 words
// Notes: word offsets are engine word addresses; byte address = 4 x word
package meter_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam real SAMPLE_HZ = 2520.62;
  localparam int unsigned SAMPLE_CYCLES = int'($floor(real'(CLK_HZ) / SAMPLE_HZ));
  localparam int unsigned DIV_W = 16;
  localparam int unsigned PULSES_PER_SAMPLE = 3;
  localparam int unsigned PULSE_FRAC_BITS = 46;
  // ----------------------------------------------------------------
  // engine memory map (word addresses)
  // ----------------------------------------------------------------
  localparam int unsigned MEM_WORDS = 256;
  localparam int unsigned ADC_SLOTS = 11;
  localparam logic [7:0] W_ADC_IA = 8'h00;
  localparam logic [7:0] W_ADC_IB = 8'h02;
  localparam logic [7:0] W_ADC_IC = 8'h04;
  localparam logic [7:0] W_ADC_VA = 8'h08;
  localparam logic [7:0] W_ADC_VB = 8'h09;
  localparam logic [7:0] W_ADC_VC = 8'h0A;
  localparam logic [7:0] W_CONFIG = 8'h20;
  localparam logic [7:0] W_RATE = 8'h21;
  localparam logic [7:0] W_DIP_LIMIT = 8'h24;
  localparam logic [7:0] W_TRIM_V = 8'h40;
  localparam logic [7:0] W_TRIM_IA = 8'h41;
  localparam logic [7:0] W_TRIM_IB = 8'h42;
  localparam logic [7:0] W_STATUS = 8'h80;
  localparam logic [7:0] W_PH0_REAL = 8'h84;
  localparam logic [7:0] W_PH0_REACT = 8'h85;
  localparam logic [7:0] W_TOTAL_REAL = 8'h86;
  localparam logic [7:0] W_REAL_PULSE_IN = 8'h88;
  localparam logic [7:0] W_REACT_PULSE_IN = 8'h89;
  // engine_config_word fields
  localparam int unsigned CFG_PULSE_SLOW = 0;
  localparam int unsigned CFG_PULSE_FAST = 1;
  localparam int unsigned CFG_OVERRIDE = 2;
  // speed factor as a left shift of the pulse increment
  localparam logic [2:0] SHIFT_NORM = 3'h2;
  localparam logic [2:0] SHIFT_SLOW = 3'h0;
  localparam logic [2:0] SHIFT_FAST = 3'h6;
  // meter equations
  localparam logic [2:0] EQ_DELTA = 3'h3;
  localparam logic [2:0] EQ_WYE2 = 3'h4;
  localparam logic [2:0] EQ_WYE3 = 3'h5;
  // ----------------------------------------------------------------
  // processor-side register map
  // ----------------------------------------------------------------
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_ACCUM = 4'h1;
  localparam logic [3:0] H_MUX = 4'h2;
  localparam logic [3:0] H_INPUTS = 4'h3;
  localparam logic [3:0] H_MEM_ADDR = 4'h4;
  localparam logic [3:0] H_MEM_WR = 4'h5;
  localparam logic [3:0] H_MEM_RD = 4'h6;
  localparam logic [3:0] H_STATUS = 4'h7;
  localparam int unsigned C_ENABLE = 0;
  localparam int unsigned C_IRQ_READY = 4;
  localparam int unsigned C_CAL_LOADED = 5;
  localparam logic [11:0] CTRL_RESET = 12'h000;
endpackage : meter_pkg

// ==== hdl/meter_link_if.sv ====
// Purpose: link between processor port and metering engine
// Assumes: single clock, both ends registered
// Notes: mem_rdata valid the cycle after mem_re
`timescale 1ns/100ps
`default_nettype none
interface meter_link_if;
  logic [9:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic mem_re;
  logic [7:0] mem_rdata;
  logic engine_enable;
  logic [2:0] eq_sel;
  logic [12:0] accum_count;
  logic [3:0] diff_en;
  logic xfer_irq;
  logic sag_warn;
  modport engine (
    input mem_addr, mem_wdata, mem_we, mem_re, engine_enable, eq_sel, accum_count, diff_en,
    output mem_rdata, xfer_irq, sag_warn
  );
  modport processor (
    output mem_addr, mem_wdata, mem_we, mem_re, engine_enable, eq_sel, accum_count, diff_en,
    input mem_rdata, xfer_irq, sag_warn
  );
endinterface : meter_link_if
`default_nettype wire

// ==== hdl/meter_pulse_gen.sv ====
// Purpose: one energy pulse generator
// Assumes: three sub ticks per sample tick
// Notes: output pulse is one clock wide
`timescale 1ns/100ps
`default_nettype none
module meter_pulse_gen (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  input wire logic sample_tick_in,
  input wire logic sub_tick_in,
  input wire logic [31:0] rate_in,
  input wire logic [31:0] level_in,
  input wire logic [2:0] shift_in,
  output logic pulse_out
);
  localparam logic [71:0] SAT_LEVEL = 72'(meter_pkg::PULSES_PER_SAMPLE) << meter_pkg::PULSE_FRAC_BITS;
  logic [47:0] acc_r;
  logic [1:0] owe_r;
  logic pulse_r;
  logic [32:0] mag;
  logic [64:0] prod;
  logic [71:0] scaled;
  logic [71:0] total;
  logic sat;
  // energy sign is dropped: both directions count
  assign mag = level_in[31] ? 33'h0 - {1'b1, level_in} : {1'b0, level_in};
  assign prod = {33'h0, rate_in} * {32'h0, mag};
  assign scaled = {7'h0, prod} << shift_in;
  assign total = {24'h0, acc_r} + scaled;
  assign sat = total >= SAT_LEVEL;
  assign pulse_out = pulse_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_r <= 48'h0;
      owe_r <= 2'h0;
      pulse_r <= 1'b0;
    end else if (!run_in) begin
      acc_r <= 48'h0;
      owe_r <= 2'h0;
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= 1'b0;
      if (sample_tick_in) begin
        if (sat) begin
          // clip instead of wrap; the residue is dropped on purpose
          owe_r <= 2'(meter_pkg::PULSES_PER_SAMPLE);
          acc_r <= 48'h0;
        end else begin
          owe_r <= total[47:46];
          acc_r <= {2'h0, total[45:0]};
        end
      end else if (sub_tick_in && owe_r != 2'h0) begin
        // fractional carry kept, so the jitter averages out
        pulse_r <= 1'b1;
        owe_r <= owe_r - 2'h1;
      end
    end
  end
endmodule : meter_pulse_gen
`default_nettype wire

// ==== hdl/meter_engine.sv ====
// Purpose: metering compute engine with byte-addressed shared memory
// Assumes: processor keeps its setup order before enabling
// Notes: arithmetic is a compact stand-in for the full program
// What this block does
// - memory words are 32-bit signed values
// - word MSB at byte 4n, LSB 4n+3
// - processor loads calibration before enabling engine
// - sample arithmetic runs at the sampling rate; pulse output at three sub ticks per sample
// - interval holds accumulation_sample_count samples
// - dip limit LSB is scaled voltage unit
// - code location, data, equation, count before enable
// - mux frame and input routing before enable
// - processor interrupt handling ready before enable
// - meter_equation_select picks the power equation
// - hardware writes converter results into slots 0-10
// - status word shows signals; config word steers
// - low voltage raises a sag warning
// - trims 0,1,2 on voltage, current A, B
// - each pass end raises result_transfer_irq
// - processor reads results before next pass
// - pulse rate scales with pulse_rate_scale and speed
// - override off copies phase-0 sums to pulse inputs
// - no creep suppression when engine drives pulses
// - pulse rate saturates at three per sample
// - pulse jitter bounded and averaging to zero
// - rate = scale x sum x fs x X / 2^46
`timescale 1ns/100ps
`default_nettype none
module meter_engine #(
  parameter int unsigned SAMPLE_CYCLES = meter_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  meter_link_if.engine link,
  input wire logic [10:0][31:0] adc_data_in,
  output logic real_pulse_out,
  output logic reactive_pulse_out
);
  localparam int unsigned SUB_CYCLES = SAMPLE_CYCLES / meter_pkg::PULSES_PER_SAMPLE;
  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_PUBLISH} eng_state_t;
  // ----------------------------------------------------------------
  // storage and declarations
  // ----------------------------------------------------------------
  logic [31:0] mem_r [0:meter_pkg::MEM_WORDS-1];
  eng_state_t state_r;
  logic [meter_pkg::DIV_W-1:0] div_cnt_r;
  logic [meter_pkg::DIV_W-1:0] sub_cnt_r;
  logic [12:0] n_cnt_r;
  logic signed [47:0] acc_real_r;
  logic signed [47:0] acc_ph0_r;
  logic signed [47:0] acc_react_r;
  logic [47:0] abs_acc_r [0:2];
  logic sag_r [0:2];
  logic f0_r;
  logic irq_r;
  logic sag_warn_r;
  logic [7:0] rdata_r;
  logic [7:0] word_idx;
  logic [4:0] lane_lsb;
  logic host_wr;
  logic run;
  logic sample_tick;
  logic sub_tick;
  logic last_sample;
  logic [31:0] cfg;
  logic override;
  logic [2:0] speed_shift;
  logic signed [31:0] va;
  logic signed [31:0] vb;
  logic signed [31:0] vc;
  logic signed [31:0] ia;
  logic signed [31:0] ib;
  logic signed [31:0] ic;
  logic signed [31:0] p_real;
  logic signed [31:0] p_ph0;
  logic signed [31:0] p_react;
  logic signed [31:0] vphase [0:2];
  logic [47:0] dip_total;

  function automatic logic signed [31:0] mulh(input logic signed [31:0] a,
                                              input logic signed [31:0] b);
    logic signed [63:0] p;
    p = a * b;
    return p[61:30];
  endfunction : mulh

  // ----------------------------------------------------------------
  // address decode and timing
  // ----------------------------------------------------------------
  assign word_idx = link.mem_addr[9:2];
  assign lane_lsb = {2'h3 - link.mem_addr[1:0], 3'h0};
  // status is engine-owned, processor writes to it are dropped
  assign host_wr = link.mem_we && (word_idx != meter_pkg::W_STATUS);
  assign run = link.engine_enable;
  assign sample_tick = run && (div_cnt_r == meter_pkg::DIV_W'(SAMPLE_CYCLES - 1));
  assign sub_tick = run && !sample_tick && (sub_cnt_r == '0);
  assign last_sample = ({3'h0, n_cnt_r} + 16'h1) >= {3'h0, link.accum_count};
  assign cfg = mem_r[meter_pkg::W_CONFIG];
  assign override = cfg[meter_pkg::CFG_OVERRIDE];
  assign speed_shift = cfg[meter_pkg::CFG_PULSE_FAST] ? meter_pkg::SHIFT_FAST :
                       cfg[meter_pkg::CFG_PULSE_SLOW] ? meter_pkg::SHIFT_SLOW :
                       meter_pkg::SHIFT_NORM;
  assign link.mem_rdata = rdata_r;
  assign link.xfer_irq = irq_r;
  assign link.sag_warn = sag_warn_r;

  // ----------------------------------------------------------------
  // per-sample arithmetic
  // ----------------------------------------------------------------
  assign va = mulh(mem_r[meter_pkg::W_ADC_VA], mem_r[meter_pkg::W_TRIM_V]);
  assign vb = mulh(mem_r[meter_pkg::W_ADC_VB], mem_r[meter_pkg::W_TRIM_V]);
  assign vc = mulh(mem_r[meter_pkg::W_ADC_VC], mem_r[meter_pkg::W_TRIM_V]);
  assign ia = mulh(link.diff_en[0] ? mem_r[0] - mem_r[1] : mem_r[meter_pkg::W_ADC_IA],
                   mem_r[meter_pkg::W_TRIM_IA]);
  assign ib = mulh(link.diff_en[1] ? mem_r[2] - mem_r[3] : mem_r[meter_pkg::W_ADC_IB],
                   mem_r[meter_pkg::W_TRIM_IB]);
  // third current has no trim of its own
  assign ic = link.diff_en[2] ? mem_r[4] - mem_r[5] : mem_r[meter_pkg::W_ADC_IC];
  // cross product stands in for a true quadrature path
  assign p_react = mulh(vb, ia) - mulh(va, ib);
  assign vphase[0] = va;
  assign vphase[1] = vb;
  assign vphase[2] = vc;
  assign dip_total = {3'h0, {13'h0, mem_r[meter_pkg::W_DIP_LIMIT]} * {32'h0, link.accum_count}};

  always_comb begin
    unique case (link.eq_sel)
      meter_pkg::EQ_DELTA: begin
        p_ph0 = mulh(va, ia - ib) >>> 1;
        p_real = p_ph0 + mulh(vc, ic);
      end
      meter_pkg::EQ_WYE2: begin
        p_ph0 = mulh(va, ia - ib) >>> 1;
        p_real = p_ph0 + (mulh(vb, ic - ib) >>> 1);
      end
      meter_pkg::EQ_WYE3: begin
        p_ph0 = mulh(va, ia);
        p_real = p_ph0 + mulh(vb, ib) + mulh(vc, ic);
      end
      default: begin
        p_ph0 = mulh(va, ia);
        p_real = p_ph0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_r <= '0;
      sub_cnt_r <= '0;
    end else if (!run || sample_tick) begin
      div_cnt_r <= '0;
      sub_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
      sub_cnt_r <= (sub_cnt_r == meter_pkg::DIV_W'(SUB_CYCLES - 1)) ? '0 : sub_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // program pass sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
      n_cnt_r <= 13'h0;
      acc_real_r <= '0;
      acc_ph0_r <= '0;
      acc_react_r <= '0;
      f0_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (!run) begin
      state_r <= ST_IDLE;
      n_cnt_r <= 13'h0;
      acc_real_r <= '0;
      acc_ph0_r <= '0;
      acc_react_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (sample_tick) state_r <= ST_CALC;
        end
        ST_CALC: begin
          acc_real_r <= acc_real_r + 48'(p_real);
          acc_ph0_r <= acc_ph0_r + 48'(p_ph0);
          acc_react_r <= acc_react_r + 48'(p_react);
          f0_r <= ~va[31];
          n_cnt_r <= n_cnt_r + 13'h1;
          state_r <= last_sample ? ST_PUBLISH : ST_IDLE;
        end
        ST_PUBLISH: begin
          irq_r <= 1'b1;
          n_cnt_r <= 13'h0;
          acc_real_r <= '0;
          acc_ph0_r <= '0;
          acc_react_r <= '0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sag detection per phase
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 3; k++) begin : g_sag
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        abs_acc_r[k] <= 48'h0;
        sag_r[k] <= 1'b0;
      end else if (!run) begin
        abs_acc_r[k] <= 48'h0;
      end else if (state_r == ST_CALC) begin
        abs_acc_r[k] <= abs_acc_r[k] + {16'h0, vphase[k][31] ? -vphase[k] : vphase[k]};
      end else if (state_r == ST_PUBLISH) begin
        // mean level compared without a divider, in dip_level_limit units
        sag_r[k] <= abs_acc_r[k] < dip_total;
        abs_acc_r[k] <= 48'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < meter_pkg::MEM_WORDS; i++) mem_r[i] <= 32'h0;
      rdata_r <= 8'h0;
      sag_warn_r <= 1'b0;
    end else begin
      if (host_wr) mem_r[word_idx][lane_lsb +: 8] <= link.mem_wdata;
      if (link.mem_re) rdata_r <= mem_r[word_idx][lane_lsb +: 8];
      // converter results win over a processor write in the same cycle
      if (sample_tick) begin
        for (int i = 0; i < meter_pkg::ADC_SLOTS; i++) mem_r[i] <= adc_data_in[i];
      end
      if (state_r == ST_PUBLISH) begin
        mem_r[meter_pkg::W_PH0_REAL] <= acc_ph0_r[47:16];
        mem_r[meter_pkg::W_PH0_REACT] <= acc_react_r[47:16];
        mem_r[meter_pkg::W_TOTAL_REAL] <= acc_real_r[47:16];
        if (!override) begin
          // no creep threshold on this path
          mem_r[meter_pkg::W_REAL_PULSE_IN] <= acc_ph0_r[47:16];
          mem_r[meter_pkg::W_REACT_PULSE_IN] <= acc_react_r[47:16];
        end
      end
      mem_r[meter_pkg::W_STATUS] <= {28'h0, f0_r, sag_r[2], sag_r[1], sag_r[0]};
      sag_warn_r <= sag_r[0] | sag_r[1] | sag_r[2];
    end
  end

  // ----------------------------------------------------------------
  // pulse generators
  // ----------------------------------------------------------------
  meter_pulse_gen u_real_pulse (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .run_in(run),
    .sample_tick_in(sample_tick),
    .sub_tick_in(sub_tick),
    .rate_in(mem_r[meter_pkg::W_RATE]),
    .level_in(mem_r[meter_pkg::W_REAL_PULSE_IN]),
    .shift_in(speed_shift),
    .pulse_out(real_pulse_out)
  );
  meter_pulse_gen u_react_pulse (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .run_in(run),
    .sample_tick_in(sample_tick),
    .sub_tick_in(sub_tick),
    .rate_in(mem_r[meter_pkg::W_RATE]),
    .level_in(mem_r[meter_pkg::W_REACT_PULSE_IN]),
    .shift_in(speed_shift),
    .pulse_out(reactive_pulse_out)
  );
endmodule : meter_engine
`default_nettype wire

// ==== hdl/meter_host.sv ====
// Purpose: processor-side port driving the metering engine
// Assumes: software register port, read data one cycle after strobe
// Notes: enable reaches the engine only once setup is complete
`timescale 1ns/100ps
`default_nettype none
module meter_host (
  input wire logic clk_in,
  input wire logic arst_n_in,
  meter_link_if.processor link,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  output logic [31:0] reg_rdata_out
);
  logic [11:0] ctrl_r;
  logic [12:0] accum_r;
  logic [3:0] mux_r;
  logic [3:0] diff_r;
  logic [2:0] setup_r;
  logic [9:0] addr_r;
  logic [7:0] wdata_r;
  logic we_r;
  logic re_r;
  logic fetch_r;
  logic [7:0] rd_byte_r;
  logic xfer_r;
  logic enable_r;
  logic [31:0] rdata_r;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_byte;
  logic setup_ok;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  assign wr_ctrl = reg_we_in && reg_addr_in == meter_pkg::H_CTRL;
  assign wr_addr = reg_we_in && reg_addr_in == meter_pkg::H_MEM_ADDR;
  assign wr_byte = reg_we_in && reg_addr_in == meter_pkg::H_MEM_WR;
  // enable is held back until every setup step has been written
  assign setup_ok = &setup_r && ctrl_r[meter_pkg::C_CAL_LOADED] &&
                    ctrl_r[meter_pkg::C_IRQ_READY];
  assign status_word = {27'h0, fetch_r | re_r, enable_r, link.sag_warn, 1'b0, xfer_r};
  assign rd_mux = reg_addr_in == meter_pkg::H_CTRL ? {20'h0, ctrl_r} :
                  reg_addr_in == meter_pkg::H_ACCUM ? {19'h0, accum_r} :
                  reg_addr_in == meter_pkg::H_MUX ? {28'h0, mux_r} :
                  reg_addr_in == meter_pkg::H_INPUTS ? {28'h0, diff_r} :
                  reg_addr_in == meter_pkg::H_MEM_ADDR ? {22'h0, addr_r} :
                  reg_addr_in == meter_pkg::H_MEM_RD ? {24'h0, rd_byte_r} :
                  reg_addr_in == meter_pkg::H_STATUS ? status_word : 32'h0;
  assign link.mem_addr = addr_r;
  assign link.mem_wdata = wdata_r;
  assign link.mem_we = we_r;
  assign link.mem_re = re_r;
  assign link.engine_enable = enable_r;
  assign link.eq_sel = ctrl_r[3:1];
  assign link.accum_count = accum_r;
  assign link.diff_en = diff_r;
  assign reg_rdata_out = rdata_r;
  // ----------------------------------------------------------------
  // setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= meter_pkg::CTRL_RESET;
      accum_r <= 13'h0;
      mux_r <= 4'h0;
      diff_r <= 4'h0;
      setup_r <= 3'h0;
      enable_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata_in[11:0];
      if (reg_we_in && reg_addr_in == meter_pkg::H_ACCUM) begin
        accum_r <= reg_wdata_in[12:0];
        setup_r[0] <= 1'b1;
      end
      if (reg_we_in && reg_addr_in == meter_pkg::H_MUX) begin
        mux_r <= reg_wdata_in[3:0];
        setup_r[1] <= 1'b1;
      end
      if (reg_we_in && reg_addr_in == meter_pkg::H_INPUTS) begin
        diff_r <= reg_wdata_in[3:0];
        setup_r[2] <= 1'b1;
      end
      enable_r <= ctrl_r[meter_pkg::C_ENABLE] && setup_ok;
      if (reg_re_in) rdata_r <= rd_mux;
    end
  end
  // ----------------------------------------------------------------
  // memory window and transfer flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_r <= 10'h0;
      wdata_r <= 8'h0;
      we_r <= 1'b0;
      re_r <= 1'b0;
      fetch_r <= 1'b0;
      rd_byte_r <= 8'h0;
      xfer_r <= 1'b0;
    end else begin
      we_r <= wr_byte;
      re_r <= wr_addr;
      fetch_r <= re_r;
      if (wr_byte) wdata_r <= reg_wdata_in[7:0];
      // byte writes walk upward so a word loads MSB first
      if (wr_addr) addr_r <= reg_wdata_in[9:0];
      else if (we_r) addr_r <= addr_r + 10'h1;
      if (fetch_r) rd_byte_r <= link.mem_rdata;
      // a new pass beats a clear in the same cycle
      if (link.xfer_irq) xfer_r <= 1'b1;
      else if (reg_we_in && reg_addr_in == meter_pkg::H_STATUS && reg_wdata_in[0]) xfer_r <= 1'b0;
    end
  end
endmodule : meter_host
`default_nettype wire

// ==== tb/meter_link_sva.sv ====
// Purpose: link checks between processor port and engine
// Assumes: one clock, async active-low reset
// Notes: spacing skips the first pass after enable
`timescale 1ns/100ps
`default_nettype none
module meter_link_sva #(
  parameter int unsigned SAMPLE_CYCLES = 30
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [9:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [7:0] mem_rdata,
  input wire logic engine_enable,
  input wire logic [2:0] eq_sel,
  input wire logic [12:0] accum_count,
  input wire logic [3:0] diff_en,
  input wire logic xfer_irq,
  input wire logic sag_warn
);
  logic [31:0] gap_r;
  logic seen_r;
  wire [31:0] span = 32'(accum_count == 13'h0 ? 13'h1 : accum_count) * SAMPLE_CYCLES;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // gap counter restarts on each pass, cleared while halted
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= !engine_enable ? 32'h0 : (xfer_irq ? 32'h1 : gap_r + 32'h1);
      seen_r <= engine_enable & (seen_r | xfer_irq);
    end
  end
  sequence two_writes;
    mem_we ##1 mem_we;
  endsequence
  sequence halted3;
    (!engine_enable) [*3];
  endsequence
  a_irq_pulse: assert property (xfer_irq |=> !xfer_irq)
    else $error("transfer pulse too long");
  a_irq_halted: assert property (halted3 |-> !xfer_irq)
    else $error("transfer pulse while halted");
  a_irq_due: assert property (engine_enable |-> gap_r <= span + 32'h4)
    else $error("pass overdue");
  a_irq_spacing: assert property (xfer_irq && seen_r |-> gap_r == span)
    else $error("pass length wrong");
  a_rdata_hold: assert property (!$past(mem_re) |-> $stable(mem_rdata))
    else $error("read byte changed without read");
  a_strobe_excl: assert property (!(mem_we && mem_re))
    else $error("read and write together");
  a_byte_step: assert property (two_writes |-> mem_addr == $past(mem_addr) + 10'h1)
    else $error("byte address did not step");
  a_sag_timing: assert property ($rose(sag_warn) |-> (seen_r && gap_r <= 32'h4) or ##[0:3] xfer_irq)
    else $error("sag outside pass end");
endmodule : meter_link_sva
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: both ends joined, driven from the register port
// Assumes: short sample period for run time
// Notes: expectations come from the register map
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  localparam int unsigned SC = 30;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [31:0] rw = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rq;
  logic [10:0][31:0] adc = {11{32'h00010203}};
  logic rp;
  logic qp;
  int checks = 0;
  int miscompares = 0;
  int cyc = 0;
  int irqs = 0;
  int pulses = 0;
  meter_link_if link();
  meter_host i_meter_host(.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link), .reg_addr_in(ra),
    .reg_wdata_in(rw), .reg_we_in(we), .reg_re_in(re), .reg_rdata_out(rq));
  meter_engine #(.SAMPLE_CYCLES(SC)) i_meter_engine(.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(link), .adc_data_in(adc), .real_pulse_out(rp), .reactive_pulse_out(qp));
  meter_link_sva #(.SAMPLE_CYCLES(SC)) i_meter_link_sva(.clk_in(clk_in), .arst_n_in(arst_n_in),
    .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata), .mem_we(link.mem_we),
    .mem_re(link.mem_re), .mem_rdata(link.mem_rdata), .engine_enable(link.engine_enable),
    .eq_sel(link.eq_sel), .accum_count(link.accum_count), .diff_en(link.diff_en),
    .xfer_irq(link.xfer_irq), .sag_warn(link.sag_warn));
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    irqs += int'(link.xfer_irq === 1'b1);
    pulses += int'(rp === 1'b1) + int'(qp === 1'b1);
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ra <= a;
    rw <= d;
    we <= 1'b1;
    re <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic idle(input int n);
    we <= 1'b0;
    re <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask : idle
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    ra <= a;
    we <= 1'b0;
    re <= 1'b1;
    @(posedge clk_in);
    re <= 1'b0;
    #1 `CHK(n, e, rq)
  endtask : rd
  task automatic peek(input logic [9:0] b, input logic [7:0] e, input string n);
    wr(meter_pkg::H_MEM_ADDR, {22'h0, b});
    idle(3);
    rd(meter_pkg::H_MEM_RD, {24'h0, e}, n);
  endtask : peek
  task automatic poke(input logic [9:0] b, input logic [31:0] w);
    wr(meter_pkg::H_MEM_ADDR, {22'h0, b});
    for (int i = 3; i >= 0; i--) wr(meter_pkg::H_MEM_WR, {24'h0, w[8*i +: 8]});
    idle(3);
  endtask : poke
  task automatic wait_irq;
    int n;
    n = irqs;
    for (int i = 0; i < 8 * SC && irqs == n; i++) @(posedge clk_in);
    `CHK("irq seen", 1'b1, irqs != n)
    idle(2);
  endtask : wait_irq
  task automatic t_setup;
    rd(meter_pkg::H_STATUS, 32'h0, "reset status");
    rd(4'hC, 32'h0, "unmapped");
    poke(10'h084, 32'h12345678);
    peek(10'h084, 8'h12, "msb");
    peek(10'h087, 8'h78, "lsb");
    poke(10'h090, 32'h7FFFFFFF);
    for (int q = 3; q <= 5; q++) begin
      wr(meter_pkg::H_CTRL, 32'h31 | (q << 1));
      idle(2);
      `CHK("eq_sel", 3'(q), link.eq_sel)
      rd(meter_pkg::H_STATUS, 32'h0, "early enable");
    end
    wr(meter_pkg::H_ACCUM, 32'h2);
    wr(meter_pkg::H_MUX, 32'h3);
    wr(meter_pkg::H_INPUTS, 32'h0);
    idle(2);
    rd(meter_pkg::H_STATUS, 32'h8, "enabled");
    `CHK("accum", 13'h2, link.accum_count)
    $display("t_setup done");
  endtask : t_setup
  task automatic t_pass;
    wait_irq();
    rd(meter_pkg::H_STATUS, 32'hD, "pass flag");
    wr(meter_pkg::H_STATUS, 32'h1);
    rd(meter_pkg::H_STATUS, 32'hC, "flag clear");
    peek(10'h020, 8'hC1, "adc msb");
    peek(10'h023, 8'hF4, "adc lsb");
    wait_irq();
    $display("t_pass done");
  endtask : t_pass
  task automatic t_pulse;
    int p;
    poke(10'h080, 32'h00000006);
    poke(10'h220, 32'h7FFFFFFF);
    idle(2 * SC);
    #1 p = pulses;
    idle(4 * SC);
    #1 `CHK("pulse sat", 12, pulses - p)
    $display("t_pulse done");
  endtask : t_pulse
  task automatic t_halt;
    int n;
    int p;
    wr(meter_pkg::H_CTRL, 32'h0);
    idle(4);
    n = irqs;
    p = pulses;
    idle(5 * SC);
    `CHK("halt irq", n, irqs)
    `CHK("halt pulses", p, pulses)
    $display("t_halt done");
  endtask : t_halt
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    adc[8] = 32'hC1D2E3F4;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_setup();
    t_pass();
    t_pulse();
    t_halt();
    conclude();
  end
endmodule : testbench
`default_nettype wire
